/* File: ctmr_cycle_timer.sv */
`timescale 1ns/10ps
`include "ctmr_map.svh"

// Periodic on/off timer driven from the stored configuration.
module ctmr_cycle_timer
  import ctmr_pkg::*;
#(
  parameter int TICK_CYCLES = `CTMR_TICK_US * `CTMR_CLK_MHZ
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_load,
  input ctmr_timer_cfg_s cfg,
  output logic hs_level,
  output logic period_pulse
);

  localparam int TW = $clog2(TICK_CYCLES);

  ctmr_tstate_e state_q; // Timer state.
  logic [TW-1:0] tick_q; // Cycles within one base tick.
  logic [23:0] count_q; // Base ticks within the current period.
  logic [23:0] on_len_q; // Selected on-time in ticks.
  logic [23:0] per_len_q; // Selected period in ticks.
  logic pulse_q; // Period boundary pulse.
  logic running;
  logic tick_end;

  // On-time lookup for the running codes.
  function automatic logic [23:0] on_ticks(input logic [2:0] code);
    case (code)
      3'h1: on_ticks = `CTMR_ON_T1;
      3'h2: on_ticks = `CTMR_ON_T2;
      3'h3: on_ticks = `CTMR_ON_T3;
      3'h4: on_ticks = `CTMR_ON_T4;
      default: on_ticks = `CTMR_ON_T5;
    endcase
  endfunction

  // Ascending period table.
  function automatic logic [23:0] per_ticks(input logic [3:0] code);
    case (code)
      4'h0: per_ticks = `CTMR_PER_T0;
      4'h1: per_ticks = `CTMR_PER_T1;
      4'h2: per_ticks = `CTMR_PER_T2;
      4'h3: per_ticks = `CTMR_PER_T3;
      4'h4: per_ticks = `CTMR_PER_T4;
      4'h5: per_ticks = `CTMR_PER_T5;
      4'h6: per_ticks = `CTMR_PER_T6;
      4'h7: per_ticks = `CTMR_PER_T7;
      4'h8: per_ticks = `CTMR_PER_T8;
      4'h9: per_ticks = `CTMR_PER_T9;
      4'ha: per_ticks = `CTMR_PER_TA;
      4'hb: per_ticks = `CTMR_PER_TB;
      4'hc: per_ticks = `CTMR_PER_TC;
      4'hd: per_ticks = `CTMR_PER_TD;
      4'he: per_ticks = `CTMR_PER_TE;
      default: per_ticks = `CTMR_PER_TF;
    endcase
  endfunction

  assign running = (state_q == CTMR_ST_ON) || (state_q == CTMR_ST_OFF);
  assign tick_end = (tick_q == TW'(TICK_CYCLES - 1));

  // Base tick prescaler, restarted with every new configuration.
  always_ff @(posedge clk) begin
    if (rst || cfg_load || !running) begin
      tick_q <= '0;
    end else if (tick_end) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + TW'(1);
    end
  end

  // A load restarts the period at once rather than finishing the old one.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= CTMR_ST_LOW;
      count_q <= 24'h000000;
      on_len_q <= `CTMR_ON_T1;
      per_len_q <= `CTMR_PER_T0;
      pulse_q <= 1'b0;
    end else if (cfg_load) begin
      count_q <= 24'h000000;
      on_len_q <= on_ticks(cfg.on_code);
      per_len_q <= per_ticks(cfg.per_code);
      pulse_q <= 1'b0;
      case (cfg.on_code)
        `CTMR_ON_OFF_LOW: state_q <= CTMR_ST_LOW;
        `CTMR_ON_OFF_HIGH: state_q <= CTMR_ST_HIGH;
        `CTMR_ON_RSVD: state_q <= CTMR_ST_LOW;
        default: state_q <= CTMR_ST_ON;
      endcase
    end else if (running && tick_end) begin
      if (count_q == per_len_q - 24'h000001) begin
        count_q <= 24'h000000;
        state_q <= CTMR_ST_ON;
        pulse_q <= 1'b1;
      end else begin
        count_q <= count_q + 24'h000001;
        pulse_q <= 1'b0;
        if (count_q + 24'h000001 == on_len_q) begin
          state_q <= CTMR_ST_OFF;
        end
      end
    end else begin
      pulse_q <= 1'b0;
    end
  end

  assign hs_level = (state_q == CTMR_ST_ON) || (state_q == CTMR_ST_HIGH);
  assign period_pulse = pulse_q;

endmodule

/* File: ctmr_map.svh */
`ifndef CTMR_MAP_SVH
`define CTMR_MAP_SVH

// Register addresses as seven-bit frame addresses.
`define CTMR_ADDR_TIMER 7'h0c
`define CTMR_ADDR_HWOPT 7'h0e

// Frame layout: write flag, seven address bits, eight data bits.
`define CTMR_FRAME_BITS 5'h10
`define CTMR_HDR_BITS 5'h08
`define CTMR_FRAME_OVER 5'h11

// Timer register field positions.
`define CTMR_RSV_BIT 7
`define CTMR_ON_MSB 6
`define CTMR_ON_LSB 4
`define CTMR_PER_MSB 3
`define CTMR_PER_LSB 0

// Hardware option register field positions.
`define CTMR_HW_UVR_BIT 7
`define CTMR_HW_RSV_HI_BIT 6
`define CTMR_HW_OWE_BIT 5
`define CTMR_HW_RDS_BIT 4
`define CTMR_HW_LOCK0_BIT 3
`define CTMR_HW_RSV_LO_MSB 2

// Reset values.
`define CTMR_TIMER_RESET 7'h00
`define CTMR_READ_ZERO 8'h00

// On-time codes that do not run the timer.
`define CTMR_ON_OFF_LOW 3'h0
`define CTMR_ON_OFF_HIGH 3'h6
`define CTMR_ON_RSVD 3'h7

// Pin configuration code that hands the high-side switch to the timer.
`define CTMR_GPIO_CYCLIC_SENSE 3'h3

// Clock rate and base tick of the timer.
`define CTMR_CLK_MHZ 100
`define CTMR_TICK_US 100

// On-times in base ticks of 0.1 ms: 0.1, 0.3, 1, 10 and 20 ms.
`define CTMR_ON_T1 24'h000001
`define CTMR_ON_T2 24'h000003
`define CTMR_ON_T3 24'h00000a
`define CTMR_ON_T4 24'h000064
`define CTMR_ON_T5 24'h0000c8

// Periods in base ticks: 10 ms up to 1000 s in 1-2-5 steps.
`define CTMR_PER_T0 24'h000064
`define CTMR_PER_T1 24'h0000c8
`define CTMR_PER_T2 24'h0001f4
`define CTMR_PER_T3 24'h0003e8
`define CTMR_PER_T4 24'h0007d0
`define CTMR_PER_T5 24'h001388
`define CTMR_PER_T6 24'h002710
`define CTMR_PER_T7 24'h004e20
`define CTMR_PER_T8 24'h00c350
`define CTMR_PER_T9 24'h0186a0
`define CTMR_PER_TA 24'h030d40
`define CTMR_PER_TB 24'h07a120
`define CTMR_PER_TC 24'h0f4240
`define CTMR_PER_TD 24'h1e8480
`define CTMR_PER_TE 24'h4c4b40
`define CTMR_PER_TF 24'h989680

`endif

/* File: ctmr_pkg.sv */
package ctmr_pkg;

  // One received frame, first bit received sits in the write flag.
  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] data;
  } ctmr_frame_s;

  // Stored timer configuration.
  typedef struct packed {
    logic [2:0] on_code;
    logic [3:0] per_code;
  } ctmr_timer_cfg_s;

  // Stored hardware options.
  typedef struct packed {
    logic uvr;
    logic owe;
    logic rds;
    logic lock0;
  } ctmr_hwopt_s;

  // Timer states.
  typedef enum logic [1:0] {
    CTMR_ST_LOW,
    CTMR_ST_HIGH,
    CTMR_ST_ON,
    CTMR_ST_OFF
  } ctmr_tstate_e;

endpackage

/* File: ctmr_regs.sv */
`timescale 1ns/10ps
`include "ctmr_map.svh"

// What this block does
// - On-time field bits 6:4, zero stops low
// - Code 110 stops high, 111 reserved
// - Period field bits 3:0, ascending 1-2-5 table
// - Timer starts itself on running on-time code
// - Restart with cyclic sense clears both fields
// - Non-restart failures keep timer settings
// - Cyclic sense and wake share one timer
// - New timer setting applies at select rise
// - Reserved bits read zero, ignore writes
// - Timer register zero on every reset
// - Timer register at its frame address
// - Option register at its frame address
// - Bit 7 selects undervoltage release threshold
// - Bit 5 selects overtemperature wait extension
// - Bit 4 selects reset delay
// - Level-0 lock blocks pump and pin changes
// - Level-1 lock guards others, survives soft reset
// - Soft reset under level-1 lock acts like restart
// - Option register reset and restart values
// - Level-1 lock arms at select rise, persists
// - Pin code 011 gives switch to timer
// - Wake bit enables timer as wake source
module ctmr_regs
  import ctmr_pkg::*;
#(
  parameter int TICK_CYCLES = `CTMR_TICK_US * `CTMR_CLK_MHZ
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic soft_reset,
  input wire logic restart_entry,
  input wire logic spi_select_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic [2:0] gpio_cfg,
  input wire logic timer_wake_source_en,
  input wire logic lock1_request,
  output logic high_side_out,
  output logic cyclic_wake_pulse,
  output logic uv_release_threshold_sel,
  output logic overtemp_wait_extend,
  output logic reset_delay_sel,
  output logic cfg_lock0,
  output logic cfg_lock1_active,
  output logic timer_running
);

  ctmr_timer_cfg_s timer_q; // Stored timer configuration.
  ctmr_hwopt_s hw_q; // Stored hardware options.
  logic lock1_q; // Level-1 lock in force.
  logic timer_load_q; // Tells the timer to take the stored setting.
  logic hs_q; // Registered high-side drive.
  logic wake_q; // Registered cyclic wake pulse.
  logic [6:0] hdr_addr; // Address of the frame in flight.
  logic [7:0] rd_data; // Read data for the frame in flight.
  ctmr_frame_s frame; // Completed frame.
  logic frame_done; // Frame ended with sixteen bits.
  logic cs_rise; // Select went high.
  logic hs_level; // Timer drive level.
  logic period_pulse; // Timer period boundary.
  logic wr_timer; // Write to the timer register.
  logic wr_hwopt; // Write to the option register.
  logic cyclic_sense; // Switch handed to the timer.

  // Serial frame receiver and read shifter.
  ctmr_spi_frame u_spi (
    .clk(clk),
    .rst(rst),
    .spi_select_n(spi_select_n),
    .spi_sck(spi_sck),
    .spi_mosi(spi_mosi),
    .rd_data(rd_data),
    .hdr_addr(hdr_addr),
    .frame(frame),
    .frame_done(frame_done),
    .cs_rise(cs_rise),
    .spi_miso(spi_miso),
    .spi_miso_oe(spi_miso_oe)
  );

  // Periodic timer shared by cyclic sense and cyclic wake.
  ctmr_cycle_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .cfg_load(timer_load_q),
    .cfg(timer_q),
    .hs_level(hs_level),
    .period_pulse(period_pulse)
  );

  // Writes are only acted on at the rising select that closes a full frame.
  assign wr_timer = frame_done && frame.wr && (frame.addr == `CTMR_ADDR_TIMER);
  assign wr_hwopt = frame_done && frame.wr && (frame.addr == `CTMR_ADDR_HWOPT);
  assign cyclic_sense = (gpio_cfg == `CTMR_GPIO_CYCLIC_SENSE);

  // Read mux; reserved bits and unmapped addresses return zero.
  always_comb begin
    rd_data = `CTMR_READ_ZERO;
    case (hdr_addr)
      `CTMR_ADDR_TIMER: begin
        rd_data[`CTMR_ON_MSB:`CTMR_ON_LSB] = timer_q.on_code;
        rd_data[`CTMR_PER_MSB:`CTMR_PER_LSB] = timer_q.per_code;
      end
      `CTMR_ADDR_HWOPT: begin
        rd_data[`CTMR_HW_UVR_BIT] = hw_q.uvr;
        rd_data[`CTMR_HW_OWE_BIT] = hw_q.owe;
        rd_data[`CTMR_HW_RDS_BIT] = hw_q.rds;
        rd_data[`CTMR_HW_LOCK0_BIT] = hw_q.lock0;
      end
      default: begin
        rd_data = `CTMR_READ_ZERO;
      end
    endcase
  end

  // Timer register. Resets of any kind force zero. Restart also covers the
  // cyclic-sense case, where the switch setting is cleared and stale timing
  // would give a wrong switch reading. Nothing else, such as a failure that
  // does not restart the device, touches the stored setting.
  always_ff @(posedge clk) begin
    if (rst || soft_reset) begin
      timer_q <= `CTMR_TIMER_RESET;
    end else if (restart_entry) begin
      timer_q <= `CTMR_TIMER_RESET;
    end else if (wr_timer) begin
      timer_q.on_code <= frame.data[`CTMR_ON_MSB:`CTMR_ON_LSB];
      timer_q.per_code <= frame.data[`CTMR_PER_MSB:`CTMR_PER_LSB];
    end
  end

  // Any change of the stored setting restarts the timer one cycle later.
  always_ff @(posedge clk) begin
    if (rst) begin
      timer_load_q <= 1'b1;
    end else begin
      timer_load_q <= soft_reset || restart_entry || wr_timer;
    end
  end

  // Level-1 lock: armed by the request only at a rising select, then held
  // until power-on; the lock itself cannot be cleared by software.
  always_ff @(posedge clk) begin
    if (rst) begin
      lock1_q <= 1'b0;
    end else if (cs_rise && lock1_request) begin
      lock1_q <= 1'b1;
    end
  end

  // Option bits guarded by the level-1 lock. Soft reset clears them only
  // when unlocked; restart keeps them; power-on clears them.
  always_ff @(posedge clk) begin
    if (rst) begin
      hw_q.uvr <= 1'b0;
      hw_q.owe <= 1'b0;
      hw_q.rds <= 1'b0;
    end else if (restart_entry) begin
      hw_q.uvr <= hw_q.uvr;
      hw_q.owe <= hw_q.owe;
      hw_q.rds <= hw_q.rds;
    end else if (soft_reset) begin
      // Under the level-1 lock the soft reset leaves the bits as restart does.
      if (!lock1_q) begin
        hw_q.uvr <= 1'b0;
        hw_q.owe <= 1'b0;
        hw_q.rds <= 1'b0;
      end
    end else if (wr_hwopt && !lock1_q) begin
      hw_q.uvr <= frame.data[`CTMR_HW_UVR_BIT];
      hw_q.owe <= frame.data[`CTMR_HW_OWE_BIT];
      hw_q.rds <= frame.data[`CTMR_HW_RDS_BIT];
    end
  end

  // Level-0 lock bit: plain read-write, cleared only at power-on. A set bit
  // keeps its value through soft reset and restart, and so does a clear one.
  always_ff @(posedge clk) begin
    if (rst) begin
      hw_q.lock0 <= 1'b0;
    end else if (wr_hwopt && !soft_reset && !restart_entry) begin
      hw_q.lock0 <= frame.data[`CTMR_HW_LOCK0_BIT];
    end
  end

  // Switch drive and wake pulse, both taken from the same timer.
  always_ff @(posedge clk) begin
    if (rst) begin
      hs_q <= 1'b0;
      wake_q <= 1'b0;
    end else begin
      hs_q <= cyclic_sense && hs_level;
      wake_q <= timer_wake_source_en && period_pulse;
    end
  end

  assign high_side_out = hs_q;
  assign cyclic_wake_pulse = wake_q;
  assign uv_release_threshold_sel = hw_q.uvr;
  assign overtemp_wait_extend = hw_q.owe;
  assign reset_delay_sel = hw_q.rds;
  assign cfg_lock0 = hw_q.lock0;
  assign cfg_lock1_active = lock1_q;
  assign timer_running = (timer_q.on_code != `CTMR_ON_OFF_LOW) &&
    (timer_q.on_code != `CTMR_ON_OFF_HIGH) && (timer_q.on_code != `CTMR_ON_RSVD);

  // Checks that tie outputs to their causes.

  // A valid write to the timer register lands the next cycle.
  sequence s_timer_write;
    wr_timer && !soft_reset && !restart_entry;
  endsequence

  // The lock request meets a rising select.
  sequence s_lock_arm;
    cs_rise && lock1_request;
  endsequence

  AST_TIMER_WRITE: assert property (@(posedge clk) disable iff (rst)
    s_timer_write |=> (timer_q == $past(frame.data[`CTMR_ON_MSB:`CTMR_PER_LSB]))
      && timer_load_q)
    else $error("timer write not stored");

  AST_TIMER_CLEAR: assert property (@(posedge clk) disable iff (rst)
    (restart_entry || soft_reset) |=> (timer_q == `CTMR_TIMER_RESET) && timer_load_q)
    else $error("timer register not cleared by reset");

  AST_RSV_READ: assert property (@(posedge clk) disable iff (rst)
    (hdr_addr == `CTMR_ADDR_HWOPT) |-> (rd_data[`CTMR_HW_RSV_HI_BIT] == 1'b0)
      && (rd_data[`CTMR_HW_RSV_LO_MSB:0] == 3'h0))
    else $error("reserved option bits read nonzero");

  AST_LOCK1_GUARD: assert property (@(posedge clk) disable iff (rst)
    (lock1_q && wr_hwopt) |=> $stable(hw_q.uvr) && $stable(hw_q.owe) && $stable(hw_q.rds))
    else $error("locked option bits changed");

  AST_SOFT_LOCKED: assert property (@(posedge clk) disable iff (rst)
    (soft_reset && lock1_q) |=> $stable(hw_q.uvr) && $stable(hw_q.owe) && $stable(hw_q.rds))
    else $error("soft reset altered locked bits");

  AST_SOFT_UNLOCKED: assert property (@(posedge clk) disable iff (rst)
    (soft_reset && !lock1_q && !restart_entry) |=> !hw_q.uvr && !hw_q.owe && !hw_q.rds)
    else $error("soft reset left option bits set");

  AST_LOCK1_ARM: assert property (@(posedge clk) disable iff (rst)
    s_lock_arm |=> lock1_q [*4])
    else $error("level-1 lock not armed or not held");

  AST_OFF_LOW: assert property (@(posedge clk) disable iff (rst)
    (timer_q.on_code == `CTMR_ON_OFF_LOW) [*3] |=> !high_side_out)
    else $error("high-side output not low with timer off");

  AST_OFF_HIGH: assert property (@(posedge clk) disable iff (rst)
    (cyclic_sense && timer_q.on_code == `CTMR_ON_OFF_HIGH) [*3] |=> high_side_out)
    else $error("high-side output not high with stop-high code");

  AST_HS_FOLLOW: assert property (@(posedge clk) disable iff (rst)
    !cyclic_sense |=> !high_side_out)
    else $error("switch driven without cyclic sense selected");

  AST_WAKE: assert property (@(posedge clk) disable iff (rst)
    (period_pulse && timer_wake_source_en) |=> cyclic_wake_pulse ##1 !cyclic_wake_pulse)
    else $error("cyclic wake pulse missing or stretched");

endmodule

/* File: ctmr_regs_bench.sv */
`timescale 1ns/10ps
`include "ctmr_map.svh"
// Self-checking bench; a short base tick keeps the timer runs brief.
module ctmr_regs_bench;
  localparam int TICK = 4;
  int on_t[8] = '{0, 1, 3, 10, 100, 200, 0, 0};
  int per_t[3] = '{100, 200, 500};
  int n_fail = 0;
  int n_tests = 0;
  int k;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic soft_reset = 1'b0;
  logic restart_entry = 1'b0;
  logic [2:0] gpio_cfg = 3'h0;
  logic timer_wake_source_en = 1'b0;
  logic lock1_request = 1'b0;
  logic spi_select_n, spi_sck, spi_mosi, spi_miso, spi_miso_oe;
  logic high_side_out, cyclic_wake_pulse, uv_release_threshold_sel;
  logic overtemp_wait_extend, reset_delay_sel, cfg_lock0, cfg_lock1_active;
  logic timer_running;

  always #5 clk = ~clk;

  ctmr_spi_host host (.clk(clk), .spi_miso(spi_miso), .spi_select_n(spi_select_n),
    .spi_sck(spi_sck), .spi_mosi(spi_mosi));

  ctmr_regs #(.TICK_CYCLES(TICK)) DUT (.clk(clk), .rst(rst), .soft_reset(soft_reset),
    .restart_entry(restart_entry), .spi_select_n(spi_select_n), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .gpio_cfg(gpio_cfg), .timer_wake_source_en(timer_wake_source_en),
    .lock1_request(lock1_request), .high_side_out(high_side_out),
    .cyclic_wake_pulse(cyclic_wake_pulse),
    .uv_release_threshold_sel(uv_release_threshold_sel),
    .overtemp_wait_extend(overtemp_wait_extend), .reset_delay_sel(reset_delay_sel),
    .cfg_lock0(cfg_lock0), .cfg_lock1_active(cfg_lock1_active),
    .timer_running(timer_running));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected %s: expected %0h, seen %0h", n, e, s);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer({1'b1, a, d}, r);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    host.xfer({1'b0, a, 8'h00}, r);
    chk($sformatf("reg %h", a), r, e);
  endtask

  // One-cycle strobes for the two reset sources.
  task automatic pulse(input bit restart);
    soft_reset = !restart;
    restart_entry = restart;
    cyc(1);
    soft_reset = 1'b0;
    restart_entry = 1'b0;
    cyc(2);
  endtask

  // Counts switch-on cycles; a bounded wait keeps a dead output from hanging.
  task automatic hicnt(input int w, output int c);
    c = 0;
    repeat (w) begin
      c += high_side_out;
      cyc(1);
    end
  endtask

  task automatic gap(output int c);
    c = 0;
    while (cyclic_wake_pulse !== 1'b1 && c < 9000) begin
      cyc(1);
      c++;
    end
    cyc(1);
    c = 1;
    while (cyclic_wake_pulse !== 1'b1 && c < 9000) begin
      cyc(1);
      c++;
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    cyc(12);
    rst = 1'b0;
    cyc(2);
    rd(`CTMR_ADDR_TIMER, 8'h00);
    rd(`CTMR_ADDR_HWOPT, 8'h00);
    rd(7'h0d, 8'h00);
    chk("miso oe", spi_miso_oe, 0);
    $display("test reset values done");
    wr(`CTMR_ADDR_TIMER, 8'hff);
    rd(`CTMR_ADDR_TIMER, 8'h7f);
    chk("running", timer_running, 0);
    wr(`CTMR_ADDR_HWOPT, 8'hff);
    rd(`CTMR_ADDR_HWOPT, 8'hb8);
    chk("uv", uv_release_threshold_sel, 1);
    chk("otw", overtemp_wait_extend, 1);
    chk("rdly", reset_delay_sel, 1);
    chk("lock0", cfg_lock0, 1);
    $display("test access done");
    pulse(1'b0);
    rd(`CTMR_ADDR_TIMER, 8'h00);
    rd(`CTMR_ADDR_HWOPT, 8'h08);
    wr(`CTMR_ADDR_HWOPT, 8'hb8);
    wr(`CTMR_ADDR_TIMER, 8'h12);
    pulse(1'b1);
    rd(`CTMR_ADDR_TIMER, 8'h00);
    rd(`CTMR_ADDR_HWOPT, 8'hb8);
    $display("test resets done");
    // The switch is handed to the timer before any on-time is written.
    gpio_cfg = 3'h3;
    for (int c = 1; c < 6; c++) begin
      wr(`CTMR_ADDR_TIMER, {1'b0, c[2:0], 4'h2});
      chk("running", timer_running, 1);
      // The first sample after a write still shows the old timer state.
      cyc(1);
      hicnt(1900, k);
      chk("on cycles", k, on_t[c] * TICK);
    end
    wr(`CTMR_ADDR_TIMER, 8'h62);
    cyc(4);
    chk("hold high", high_side_out, 1);
    gpio_cfg = 3'h4;
    cyc(4);
    chk("not owned", high_side_out, 0);
    gpio_cfg = 3'h3;
    wr(`CTMR_ADDR_TIMER, 8'h02);
    cyc(4);
    chk("hold low", high_side_out, 0);
    chk("stopped", timer_running, 0);
    $display("test on-times done");
    timer_wake_source_en = 1'b1;
    for (int p = 0; p < 3; p++) begin
      wr(`CTMR_ADDR_TIMER, {4'h1, p[3:0]});
      gap(k);
      chk("period", k, per_t[p] * TICK);
    end
    wr(`CTMR_ADDR_TIMER, 8'h10);
    timer_wake_source_en = 1'b0;
    k = 0;
    repeat (500) begin
      cyc(1);
      k += cyclic_wake_pulse;
    end
    chk("wake off", k, 0);
    $display("test periods done");
    lock1_request = 1'b1;
    rd(`CTMR_ADDR_HWOPT, 8'hb8);
    chk("lock1", cfg_lock1_active, 1);
    wr(`CTMR_ADDR_HWOPT, 8'h00);
    rd(`CTMR_ADDR_HWOPT, 8'hb0);
    pulse(1'b0);
    rd(`CTMR_ADDR_HWOPT, 8'hb0);
    lock1_request = 1'b0;
    rd(`CTMR_ADDR_HWOPT, 8'hb0);
    chk("lock1 kept", cfg_lock1_active, 1);
    $display("test locks done");
    end_sim();
  end

  // The tests need about 20000 cycles; this limit leaves ample slack.
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    $display("unexpected watchdog: expected end of tests, seen timeout");
    end_sim();
  end
endmodule

/* File: ctmr_spi_frame.sv */
`timescale 1ns/10ps
`include "ctmr_map.svh"

// Serial frame receiver, mode 0, MSB first, sampled in the system clock domain.
// The serial clock must stay at least two system clocks in each phase.
module ctmr_spi_frame
  import ctmr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic spi_select_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  input wire logic [7:0] rd_data,
  output logic [6:0] hdr_addr,
  output ctmr_frame_s frame,
  output logic frame_done,
  output logic cs_rise,
  output logic spi_miso,
  output logic spi_miso_oe
);

  logic sck_q; // Previous serial clock level.
  logic cs_n_q; // Previous select level.
  logic [4:0] bit_cnt_q; // Bits received in this frame, saturating.
  logic [15:0] rx_q; // Receive shift register.
  logic [7:0] tx_q; // Transmit shift register.
  logic tx_loaded_q; // Read data already captured this frame.
  logic frame_done_q; // Frame end pulse.
  logic cs_rise_q; // Select rising pulse.
  logic sck_rise;
  logic sck_fall;

  assign sck_rise = spi_sck & ~sck_q & ~spi_select_n;
  assign sck_fall = ~spi_sck & sck_q & ~spi_select_n;

  // Edge history of the serial pins.
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sck_q <= spi_sck;
      cs_n_q <= spi_select_n;
    end
  end

  // Receive path; extra bits mark the frame as overlong so it is dropped.
  always_ff @(posedge clk) begin
    if (rst || spi_select_n) begin
      bit_cnt_q <= 5'h00;
      if (rst) begin
        rx_q <= 16'h0000;
      end
    end else if (sck_rise) begin
      rx_q <= {rx_q[14:0], spi_mosi};
      if (bit_cnt_q != `CTMR_FRAME_OVER) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // Transmit path: a zero header byte, then the addressed register.
  always_ff @(posedge clk) begin
    if (rst || spi_select_n) begin
      tx_q <= 8'h00;
      tx_loaded_q <= 1'b0;
    end else if (bit_cnt_q == `CTMR_HDR_BITS && !tx_loaded_q) begin
      tx_q <= rd_data;
      tx_loaded_q <= 1'b1;
    end else if (sck_fall && bit_cnt_q > `CTMR_HDR_BITS) begin
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // Frame end is only reported for a frame of exactly sixteen bits.
  always_ff @(posedge clk) begin
    if (rst) begin
      frame_done_q <= 1'b0;
      cs_rise_q <= 1'b0;
    end else begin
      cs_rise_q <= spi_select_n & ~cs_n_q;
      frame_done_q <= spi_select_n & ~cs_n_q & (bit_cnt_q == `CTMR_FRAME_BITS);
    end
  end

  // Frame end takes the count from the cycle of the rising select, before it clears.
  assign hdr_addr = rx_q[6:0];
  assign frame = rx_q;
  assign frame_done = frame_done_q;
  assign cs_rise = cs_rise_q;
  assign spi_miso = tx_q[7];
  assign spi_miso_oe = ~spi_select_n;

endmodule

/* File: ctmr_spi_host.sv */
`timescale 1ns/10ps
// Host model: sends mode 0 frames, four system clocks low and three high per serial bit.
module ctmr_spi_host (
  input wire logic clk,
  input wire logic spi_miso,
  output logic spi_select_n,
  output logic spi_sck,
  output logic spi_mosi
);
  // The serial clock stands low and select stays high outside frames.
  initial begin
    spi_select_n = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
  end

  // One whole frame, MSB first; the answer byte is sampled before each late rise.
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk);
      #1;
      spi_select_n = 1'b0;
      spi_mosi = tx[i];
      repeat (3) @(posedge clk);
      #1;
      if (i < 8) begin
        rx[i] = spi_miso;
      end
      spi_sck = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      spi_sck = 1'b0;
    end
    repeat (2) @(posedge clk);
    #1;
    // Raising select ends the frame and commits a write.
    spi_select_n = 1'b1;
    // A released data line must not keep showing the last bit.
    spi_mosi = ~spi_mosi;
    repeat (3) @(posedge clk);
    #1;
  endtask
endmodule
